// *** logic/dslfs_pkg.sv ***
// Package: register map, field layouts, timing constants and carrier types for the speed loop supervisor
package dslfs_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] DSLFS_OFF_MODE = 8'h00; // Operating mode select
	localparam logic [7:0] DSLFS_OFF_MINF = 8'h04; // Minimum frequency
	localparam logic [7:0] DSLFS_OFF_MAXF = 8'h08; // Maximum frequency
	localparam logic [7:0] DSLFS_OFF_FIXF = 8'h0C; // Fixed frequency
	localparam logic [7:0] DSLFS_OFF_PRE_A = 8'h10; // Preset frequency a
	localparam logic [7:0] DSLFS_OFF_PRE_B = 8'h14; // Preset frequency b
	localparam logic [7:0] DSLFS_OFF_PRE_C = 8'h18; // Preset frequency c
	localparam logic [7:0] DSLFS_OFF_PRE_D = 8'h1C; // Preset frequency d
	localparam logic [7:0] DSLFS_OFF_LOOPEN = 8'h20; // Speed loop enable
	localparam logic [7:0] DSLFS_OFF_SCALE = 8'h24; // Feedback scale
	localparam logic [7:0] DSLFS_OFF_KP = 8'h28; // Proportional gain
	localparam logic [7:0] DSLFS_OFF_KI = 8'h2C; // Integral gain
	localparam logic [7:0] DSLFS_OFF_KD = 8'h30; // Differential gain
	localparam logic [7:0] DSLFS_OFF_SLIP = 8'h34; // Slip limit
	localparam logic [7:0] DSLFS_OFF_SPER = 8'h38; // Feedback sample period
	localparam logic [7:0] DSLFS_OFF_ACTF = 8'h3C; // Actual frequency readout
	localparam logic [7:0] DSLFS_OFF_REQF = 8'h40; // Frequency request, the target in open and closed loop outside fixed mode
	localparam logic [7:0] DSLFS_OFF_FAULT = 8'h44; // Latched fault flags
	localparam logic [7:0] DSLFS_OFF_OUTF = 8'h48; // Output frequency

	// ------------------------------------------------------------
	// Field layout and values
	// ------------------------------------------------------------
	localparam int DSLFS_FW = 16; // Frequency word width
	localparam logic [7:0] DSLFS_MODE_FIXED = 8'h03; // Fixed frequency mode selector
	localparam int DSLFS_NFLT = 10; // Number of fault flags
	localparam int DSLFS_FB_PARAM = 0; // Min above max
	localparam int DSLFS_FB_FIXED = 1; // Fixed outside limits
	localparam int DSLFS_FB_PRE0 = 2; // Presets a..d at bits 2..5
	localparam int DSLFS_FB_TRIP = 6; // External trip
	localparam int DSLFS_FB_ADC = 7; // Converter fault
	localparam int DSLFS_FB_FBHI = 8; // Feedback above 50 V
	localparam int DSLFS_FB_NEG = 9; // Negative feedback
	localparam logic [15:0] DSLFS_FB_MAX_CODE = 16'h7FFF; // Code for 50 V full scale
	localparam logic [15:0] DSLFS_RST_MAXF = 16'h01F4; // Reset max frequency
	localparam logic [15:0] DSLFS_RST_SCALE = 16'h0100; // Scale 1.0 in 8.8
	localparam logic [7:0] DSLFS_RST_SPER = 8'h01; // One sample tick

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int DSLFS_CLK_MHZ = 250; // Clock rate
	localparam int DSLFS_TICK_MS = 30; // Sample tick in ms
	localparam int DSLFS_TICK_CYC = DSLFS_TICK_MS * 1000 * DSLFS_CLK_MHZ; // Cycles per tick

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic run; // Run/stop input level
		logic trip; // External trip input
		logic adc_err; // Converter error flag
		logic [15:0] fb; // Signed feedback code
	} dslfs_in_t;

	typedef struct packed {
		logic [7:0] mode;
		logic [15:0] minf;
		logic [15:0] maxf;
		logic [15:0] fixf;
		logic [3:0][15:0] pre;
		logic loop_en;
		logic [15:0] scale;
		logic [15:0] kp;
		logic [15:0] ki;
		logic [15:0] kd;
		logic [15:0] slip;
		logic [7:0] sper;
		logic [15:0] reqf;
	} dslfs_cfg_t;

endpackage : dslfs_pkg

// *** logic/dslfs_top.sv ***
// Speed loop fault supervisor: APB registers, fault latches, relay and PID regulator
// Behaviour
// - Fault when minimum exceeds maximum frequency
// - Fixed frequency out of limits, mode 003
// - Separate fault per preset out of limits
// - External trip latches until removed and restart
// - Report converter malfunction fault
// - Fault when feedback exceeds 50 V; never raised, as any code above 7FFF has bit 15 set and counts as negative
// - Stop-then-run or power cycle clears faults
// - Relay energised unless any fault present
// - Closed loop drives feedback to request
// - Feedback times scale gives actual frequency
// - Actual frequency readable, display only
// - Fixed mode ramps to fixed frequency
// - Negative feedback never treated as speed
// - Correction from P, I, D gains
// - Clamp actual/output difference to slip limit
// - Actual refreshed every N times 30 ms
module dslfs_top
	import dslfs_pkg::*;
#(
	parameter int TICK_CYC = DSLFS_TICK_CYC // Cycles per 30 ms tick
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Terminals and feedback
	input wire logic run_stop_input,
	input wire logic external_trip_input,
	input wire logic adc_error_input,
	input wire logic [15:0] speed_feedback_input,
	// Drive outputs
	output logic fault_relay,
	output logic [15:0] output_freq,
	output logic drive_running
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		dslfs_in_t s1; // First synchroniser stage
		dslfs_in_t s2; // Second synchroniser stage
		dslfs_cfg_t cfg; // Software settings
		logic [DSLFS_NFLT-1:0] flt; // Latched faults
		logic run_d; // Previous run level
		logic stopped; // Stop seen since last restart
		logic [31:0] tick_cnt; // 30 ms divider
		logic [7:0] per_cnt; // Ticks in sample period
		logic [15:0] actf; // Sampled actual frequency
		logic signed [17:0] err_d; // Previous error
		logic signed [31:0] integ; // Integral accumulator
		logic [15:0] outf; // Output frequency
		logic [31:0] rdata; // Read data
	} dslfs_state_t;

	dslfs_state_t st_reg; // Registered state
	dslfs_state_t st_next; // Next state

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Range check shared by fixed and preset frequencies
	function automatic logic dslfs_out_of_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		dslfs_out_of_range = (v > hi) || (v < lo);
	endfunction : dslfs_out_of_range

	// Saturate a signed value to 0..65535
	function automatic logic [15:0] dslfs_sat16(input logic signed [33:0] v);
		if (v < 0) begin
			dslfs_sat16 = 16'h0000;
		end else if (v > 34'sd65535) begin
			dslfs_sat16 = 16'hFFFF;
		end else begin
			dslfs_sat16 = v[15:0];
		end
	endfunction : dslfs_sat16

	// ------------------------------------------------------------
	// Combinational helpers
	// ------------------------------------------------------------
	logic acc; // APB access phase
	logic [DSLFS_NFLT-1:0] cond; // Live fault conditions
	logic [31:0] scaled; // Feedback times scale
	logic [15:0] fb_pos; // Feedback, negatives forced to zero
	logic [15:0] target; // Requested frequency
	logic sample; // Sample point
	logic tick; // 30 ms tick
	logic signed [17:0] err; // Target minus actual
	logic signed [33:0] corr; // PID correction
	logic [15:0] lo_lim; // Slip lower bound
	logic [15:0] hi_lim; // Slip upper bound
	logic [15:0] want; // Unclamped output

	assign acc = psel && penable;

	// Live fault conditions from settings and synchronised inputs
	always_comb begin
		cond = '0;
		cond[DSLFS_FB_PARAM] = st_reg.cfg.minf > st_reg.cfg.maxf;
		cond[DSLFS_FB_FIXED] = (st_reg.cfg.mode == DSLFS_MODE_FIXED) &&
			dslfs_out_of_range(st_reg.cfg.fixf, st_reg.cfg.minf, st_reg.cfg.maxf);
		for (int i = 0; i < 4; i++) begin
			cond[DSLFS_FB_PRE0 + i] = dslfs_out_of_range(st_reg.cfg.pre[i], st_reg.cfg.minf, st_reg.cfg.maxf);
		end
		cond[DSLFS_FB_TRIP] = st_reg.s2.trip;
		cond[DSLFS_FB_ADC] = st_reg.s2.adc_err;
		cond[DSLFS_FB_FBHI] = !st_reg.s2.fb[15] && (st_reg.s2.fb > DSLFS_FB_MAX_CODE);
		cond[DSLFS_FB_NEG] = st_reg.s2.fb[15] && st_reg.cfg.loop_en;
	end

	// Regulator arithmetic
	always_comb begin
		fb_pos = st_reg.s2.fb[15] ? 16'h0000 : st_reg.s2.fb;
		scaled = fb_pos * st_reg.cfg.scale;
		tick = st_reg.tick_cnt == 32'(TICK_CYC - 1);
		sample = tick && (st_reg.per_cnt + 8'h01 >= st_reg.cfg.sper);
		target = (st_reg.cfg.mode == DSLFS_MODE_FIXED) ? st_reg.cfg.fixf : st_reg.cfg.reqf;
		err = 18'(signed'({2'b00, target})) - 18'(signed'({2'b00, st_reg.actf}));
		corr = 34'(signed'({1'b0, st_reg.cfg.kp}) * err) + 34'(st_reg.integ + signed'({1'b0, st_reg.cfg.ki}) * err)
			+ 34'(signed'({1'b0, st_reg.cfg.kd}) * (err - st_reg.err_d));
		want = dslfs_sat16(34'(signed'({2'b00, target})) + (corr >>> 8));
		lo_lim = (st_reg.actf > st_reg.cfg.slip) ? st_reg.actf - st_reg.cfg.slip : 16'h0000;
		hi_lim = dslfs_sat16(34'(st_reg.actf) + 34'(st_reg.cfg.slip));
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		// Two-stage input synchroniser
		st_next.s1 = '{run: run_stop_input, trip: external_trip_input,
			adc_err: adc_error_input, fb: speed_feedback_input};
		st_next.s2 = st_reg.s1;
		st_next.run_d = st_reg.s2.run;
		// Stop-then-run clears; new conditions win over the clear
		if (!st_reg.s2.run) begin
			st_next.stopped = 1'b1;
		end
		if (st_reg.s2.run && !st_reg.run_d && st_reg.stopped) begin
			st_next.flt = cond;
			st_next.stopped = 1'b0;
		end else begin
			st_next.flt = st_reg.flt | cond;
		end
		// Sample tick divider
		if (tick) begin
			st_next.tick_cnt = '0;
			st_next.per_cnt = sample ? 8'h00 : st_reg.per_cnt + 8'h01;
		end else begin
			st_next.tick_cnt = st_reg.tick_cnt + 32'h1;
		end
		// Regulator update once per sample period
		if (sample) begin
			st_next.actf = scaled[23:8];
			if (st_reg.cfg.loop_en && st_reg.s2.run && st_reg.flt == '0) begin
				st_next.integ = st_reg.integ + 32'(signed'({1'b0, st_reg.cfg.ki}) * err);
				st_next.err_d = err;
				// Clamp to the slip window around actual frequency
				if (want > hi_lim) begin
					st_next.outf = hi_lim;
				end else if (want < lo_lim) begin
					st_next.outf = lo_lim;
				end else begin
					st_next.outf = want;
				end
			end
		end
		// Open loop follows the request directly
		if (!st_reg.cfg.loop_en) begin
			st_next.outf = target;
			st_next.integ = '0;
			st_next.err_d = '0;
		end
		if (!st_reg.s2.run || st_reg.flt != '0) begin
			st_next.outf = 16'h0000;
			st_next.integ = '0;
		end
		// APB writes
		if (acc && pwrite) begin
			case (paddr)
				DSLFS_OFF_MODE: st_next.cfg.mode = pwdata[7:0];
				DSLFS_OFF_MINF: st_next.cfg.minf = pwdata[15:0];
				DSLFS_OFF_MAXF: st_next.cfg.maxf = pwdata[15:0];
				DSLFS_OFF_FIXF: st_next.cfg.fixf = pwdata[15:0];
				DSLFS_OFF_PRE_A: st_next.cfg.pre[0] = pwdata[15:0];
				DSLFS_OFF_PRE_B: st_next.cfg.pre[1] = pwdata[15:0];
				DSLFS_OFF_PRE_C: st_next.cfg.pre[2] = pwdata[15:0];
				DSLFS_OFF_PRE_D: st_next.cfg.pre[3] = pwdata[15:0];
				DSLFS_OFF_LOOPEN: st_next.cfg.loop_en = pwdata[0];
				DSLFS_OFF_SCALE: st_next.cfg.scale = pwdata[15:0];
				DSLFS_OFF_KP: st_next.cfg.kp = pwdata[15:0];
				DSLFS_OFF_KI: st_next.cfg.ki = pwdata[15:0];
				DSLFS_OFF_KD: st_next.cfg.kd = pwdata[15:0];
				DSLFS_OFF_SLIP: st_next.cfg.slip = pwdata[15:0];
				DSLFS_OFF_SPER: st_next.cfg.sper = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
				DSLFS_OFF_REQF: st_next.cfg.reqf = pwdata[15:0];
				default: ; // Read-only or unmapped: ignored
			endcase
		end
		// APB read data captured in setup so it is ready in access
		if (psel && !penable && !pwrite) begin
			case (paddr)
				DSLFS_OFF_MODE: st_next.rdata = {24'h0, st_reg.cfg.mode};
				DSLFS_OFF_MINF: st_next.rdata = {16'h0, st_reg.cfg.minf};
				DSLFS_OFF_MAXF: st_next.rdata = {16'h0, st_reg.cfg.maxf};
				DSLFS_OFF_FIXF: st_next.rdata = {16'h0, st_reg.cfg.fixf};
				DSLFS_OFF_PRE_A: st_next.rdata = {16'h0, st_reg.cfg.pre[0]};
				DSLFS_OFF_PRE_B: st_next.rdata = {16'h0, st_reg.cfg.pre[1]};
				DSLFS_OFF_PRE_C: st_next.rdata = {16'h0, st_reg.cfg.pre[2]};
				DSLFS_OFF_PRE_D: st_next.rdata = {16'h0, st_reg.cfg.pre[3]};
				DSLFS_OFF_LOOPEN: st_next.rdata = {31'h0, st_reg.cfg.loop_en};
				DSLFS_OFF_SCALE: st_next.rdata = {16'h0, st_reg.cfg.scale};
				DSLFS_OFF_KP: st_next.rdata = {16'h0, st_reg.cfg.kp};
				DSLFS_OFF_KI: st_next.rdata = {16'h0, st_reg.cfg.ki};
				DSLFS_OFF_KD: st_next.rdata = {16'h0, st_reg.cfg.kd};
				DSLFS_OFF_SLIP: st_next.rdata = {16'h0, st_reg.cfg.slip};
				DSLFS_OFF_SPER: st_next.rdata = {24'h0, st_reg.cfg.sper};
				DSLFS_OFF_ACTF: st_next.rdata = {16'h0, st_reg.actf};
				DSLFS_OFF_REQF: st_next.rdata = {16'h0, st_reg.cfg.reqf};
				DSLFS_OFF_FAULT: st_next.rdata = {22'h0, st_reg.flt};
				DSLFS_OFF_OUTF: st_next.rdata = {16'h0, st_reg.outf};
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Only constants under reset; power cycle clears every fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.cfg.maxf <= DSLFS_RST_MAXF;
			st_reg.cfg.scale <= DSLFS_RST_SCALE;
			st_reg.cfg.sper <= DSLFS_RST_SPER;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata = st_reg.rdata;
	assign pready = 1'b1; // Zero wait states
	assign pslverr = 1'b0;
	assign fault_relay = (st_reg.flt == '0);
	assign output_freq = st_reg.outf;
	assign drive_running = st_reg.s2.run && (st_reg.flt == '0);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_param_fault: assert property (cond[DSLFS_FB_PARAM] |=> st_reg.flt[DSLFS_FB_PARAM])
		else $error("min above max not latched");
	a_fixed_gate: assert property ((st_reg.cfg.mode != DSLFS_MODE_FIXED) |-> !cond[DSLFS_FB_FIXED])
		else $error("fixed check active outside fixed mode");
	a_preset_fault: assert property ((st_reg.cfg.pre[0] > st_reg.cfg.maxf) |=> st_reg.flt[DSLFS_FB_PRE0])
		else $error("preset a fault not latched");
	a_trip_latch: assert property ($rose(external_trip_input) |-> ##3 st_reg.flt[DSLFS_FB_TRIP])
		else $error("external trip not latched in three cycles");
	a_adc_fault: assert property (st_reg.s2.adc_err |=> !fault_relay)
		else $error("converter fault missed");
	a_fb_high: assert property ((st_reg.s2.fb > DSLFS_FB_MAX_CODE && !st_reg.s2.fb[15]) |=> st_reg.flt[DSLFS_FB_FBHI])
		else $error("feedback over limit missed");
	a_hold_fault: assert property ((st_reg.flt != '0 && !(st_reg.s2.run && !st_reg.run_d)) |=> st_reg.flt != '0)
		else $error("fault dropped without restart");
	a_relay_state: assert property ((st_reg.flt != '0) |-> !fault_relay ##1 1)
		else $error("relay energised with fault");
	a_slip_clamp: assert property ((sample && st_reg.cfg.loop_en && st_reg.s2.run && st_reg.flt == '0)
		|=> (st_reg.outf <= $past(hi_lim)) && (st_reg.outf >= $past(lo_lim)))
		else $error("slip clamp violated");
	a_open_loop: assert property ((!st_reg.cfg.loop_en && st_reg.s2.run && st_reg.flt == '0 && $stable(target))
		|=> st_reg.outf == $past(target))
		else $error("open loop not following request");

	c_trip: cover property ($rose(st_reg.flt[DSLFS_FB_TRIP]) ##[1:20] $fell(st_reg.flt[DSLFS_FB_TRIP]));
	c_sample: cover property (sample && st_reg.cfg.loop_en);
	c_clamp: cover property (sample && want > hi_lim);
	c_param: cover property (cond[DSLFS_FB_PARAM]);

endmodule : dslfs_top

// *** test/dslfs_partner.sv ***
// Far side model: operator terminals and a tachometer that tracks output frequency
module dslfs_partner
	import dslfs_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Commands from the bench
	input wire logic run_cmd,
	input wire logic trip_cmd,
	input wire logic adc_cmd,
	input wire logic fb_hold,
	input wire logic [15:0] fb_value,
	// Drive output seen by the motor
	input wire logic [15:0] output_freq,
	// Terminals
	output logic run_stop_input,
	output logic external_trip_input,
	output logic adc_error_input,
	output logic [15:0] speed_feedback_input
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Terminal levels, moved just after an edge
	// ----------------------------------------
	// Operator gives stop then run to clear faults
	always_ff @(posedge pclk) begin
		run_stop_input <= run_cmd;
		external_trip_input <= trip_cmd;
		adc_error_input <= adc_cmd;
		// Tacho lags the drive by one cycle; positive unless held negative by a scenario
		speed_feedback_input <= fb_hold ? fb_value : output_freq;
	end
endmodule : dslfs_partner

// *** test/dslfs_top_test.sv ***
// Self-checking bench for the speed loop fault supervisor
module dslfs_top_test
	import dslfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, a, b;
	logic run_stop_input, external_trip_input, adc_error_input, fault_relay, drive_running;
	logic [15:0] speed_feedback_input, output_freq, fb_value;
	logic run_cmd, trip_cmd, adc_cmd, fb_hold;
	logic [9:0] lat; // Model of latched flags
	int cfg [0:18]; // Model of written settings
	int errors, checks_done, n, i;

	always #2 pclk = ~pclk;

	dslfs_top #(.TICK_CYC(10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.run_stop_input(run_stop_input), .external_trip_input(external_trip_input),
		.adc_error_input(adc_error_input), .speed_feedback_input(speed_feedback_input),
		.fault_relay(fault_relay), .output_freq(output_freq), .drive_running(drive_running));

	dslfs_partner u_far (.pclk(pclk), .run_cmd(run_cmd), .trip_cmd(trip_cmd), .adc_cmd(adc_cmd),
		.fb_hold(fb_hold), .fb_value(fb_value), .output_freq(output_freq), .run_stop_input(run_stop_input),
		.external_trip_input(external_trip_input), .adc_error_input(adc_error_input),
		.speed_feedback_input(speed_feedback_input));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task end_of_test;
		if (errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk

	// xorshift source of stimulus values
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xorshift

	task rnd;
		seed = xorshift(seed);
	endtask : rnd

	// One APB transfer; request held until pready is seen high
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			chk(0, 1, "apb timeout");
			end_of_test;
		end
	endtask : apb

	task wr(input logic [7:0] ad, input logic [31:0] d);
		cfg[ad >> 2] = d;
		apb(1'b1, ad, d);
	endtask : wr

	task rdc(input logic [7:0] ad, input logic [31:0] exp, input string m);
		apb(1'b0, ad, 32'h0);
		chk(rd, exp, m);
	endtask : rdc

	// Setting faults predicted from the written values
	function automatic logic [9:0] cfg_flags();
		logic [9:0] f;
		f = '0;
		f[0] = cfg[1] > cfg[2];
		f[1] = cfg[0] == 3 && (cfg[3] < cfg[1] || cfg[3] > cfg[2]);
		for (int j = 0; j < 4; j++) f[2 + j] = cfg[4 + j] > cfg[2] || cfg[4 + j] < cfg[1];
		return f;
	endfunction : cfg_flags

	// Flags latch on top of what was already latched; relay follows
	task fchk(input logic [9:0] live);
		lat = lat | cfg_flags() | live;
		repeat (6) @(posedge pclk);
		rdc(DSLFS_OFF_FAULT, {22'h0, lat}, "fault flags");
		chk(fault_relay, lat == 0, "relay");
	endtask : fchk

	// Stop then run; conditions still present stay latched
	task clr(input logic [9:0] live);
		@(posedge pclk);
		run_cmd <= 1'b0;
		repeat (4) @(posedge pclk);
		run_cmd <= 1'b1;
		repeat (6) @(posedge pclk);
		lat = cfg_flags() | live;
	endtask : clr

	task waitf(input logic [15:0] v, input string m);
		n = 0;
		while (output_freq !== v && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		chk(output_freq, v, m);
		if (n >= 20000) begin
			end_of_test;
		end
	endtask : waitf

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, trip_cmd, adc_cmd, fb_hold, fb_value} = '0;
		run_cmd = 1'b1;
		{errors, checks_done, lat} = '0;
		seed = 32'h8792;
		foreach (cfg[k]) cfg[k] = 0;
		cfg[2] = 32'h1F4;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdc(DSLFS_OFF_MAXF, 32'h1F4, "max reset");
		rdc(DSLFS_OFF_SCALE, 32'h100, "scale reset");
		rdc(DSLFS_OFF_SPER, 32'h1, "period reset");
		rdc(8'h4C, 32'h0, "unmapped");
		fchk(0);
		wr(DSLFS_OFF_ACTF, 32'h1234);
		rdc(DSLFS_OFF_ACTF, 32'h0, "readout write");
		wr(DSLFS_OFF_SPER, 32'h0);
		rdc(DSLFS_OFF_SPER, 32'h1, "period zero");
		wr(DSLFS_OFF_MINF, 32'h200);
		fchk(0);
		wr(DSLFS_OFF_MINF, 32'h0);
		fchk(0);
		clr(0);
		fchk(0);
		for (i = 0; i < 4; i++) begin
			rnd;
			wr(DSLFS_OFF_PRE_A + 8'(4 * i), 32'h1F5 + (seed & 32'hFF));
			fchk(0);
			wr(DSLFS_OFF_PRE_A + 8'(4 * i), 32'h0);
			clr(0);
			fchk(0);
		end
		wr(DSLFS_OFF_FIXF, 32'h300);
		fchk(0);
		wr(DSLFS_OFF_MODE, 32'h3);
		fchk(0);
		wr(DSLFS_OFF_FIXF, 32'h100);
		clr(0);
		waitf(16'h0100, "fixed ramp");
		wr(DSLFS_OFF_MODE, 32'h0);
		trip_cmd <= 1'b1;
		fchk(10'h040);
		chk(output_freq, 0, "output while faulted");
		clr(10'h040);
		fchk(0);
		trip_cmd <= 1'b0;
		clr(0);
		fchk(0);
		adc_cmd <= 1'b1;
		fchk(10'h080);
		adc_cmd <= 1'b0;
		clr(0);
		fchk(0);
		rnd;
		wr(DSLFS_OFF_LOOPEN, 32'h1);
		fb_hold <= 1'b1;
		fb_value <= 16'h8000 | seed[15:0];
		fchk(10'h200);
		rnd;
		b = 32'h80 + (seed & 32'hFF);
		a = (seed >> 8) & 32'hFF;
		fb_value <= a[15:0];
		clr(0);
		wr(DSLFS_OFF_SCALE, b);
		repeat (40) @(posedge pclk);
		rdc(DSLFS_OFF_ACTF, (a * b) >> 8, "actual freq");
		wr(DSLFS_OFF_SCALE, 32'h100);
		fb_value <= 16'h0040;
		wr(DSLFS_OFF_SLIP, 32'h10);
		wr(DSLFS_OFF_KP, 32'h40);
		wr(DSLFS_OFF_REQF, 32'h150);
		repeat (300) @(posedge pclk);
		chk(output_freq > 16'h0050, 0, "slip clamp");
		wr(DSLFS_OFF_LOOPEN, 32'h0);
		fb_hold <= 1'b0;
		wr(DSLFS_OFF_REQF, 32'h80);
		waitf(16'h0080, "open loop");
		wr(DSLFS_OFF_KI, 32'h0);
		wr(DSLFS_OFF_KD, 32'h0);
		wr(DSLFS_OFF_LOOPEN, 32'h1);
		wr(DSLFS_OFF_REQF, 32'h100);
		waitf(16'h0100, "closed loop");
		// Power cycle in mid-run clears a latched fault
		wr(DSLFS_OFF_MINF, 32'h200);
		repeat (6) @(posedge pclk);
		chk(fault_relay, 0, "relay before power cycle");
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		rdc(DSLFS_OFF_FAULT, 32'h0, "power cycle clear");
		chk(fault_relay, 1, "relay after power cycle");
		end_of_test;
	end
endmodule : dslfs_top_test
